// ===== dv/msb_far_side.sv
/*
 * far-side model of the muxed bus: one block of target memory that answers
 * each data phase with acknowledge, retry or bus fault.
 * assumes the unit passes answers through a three-flop synchroniser, so each
 * answer is held six bus clocks and then released for at least three.
 */
module msb_far_side (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [31:0] ad_o,
	input wire logic ad_oe,
	input wire logic [1:0] word_index,
	input wire logic data_phase_n,
	input wire logic write_n,
	input wire logic [1:0] answer, // 0 ack, 1 retry, 2 fault, 3 fault with ack
	input wire logic [3:0] slow, // extra wait clocks per data phase
	output logic [31:0] ad_i,
	output logic ack_n,
	output logic retry_n,
	output logic bus_fault_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [4]; // one block of target words
	logic [1:0] seq [8]; // log of answered word indices
	int nb = 0; // data phases answered so far
	logic drv = 1'h0; // target drives read data
	logic [31:0] rdat = 32'h0; // read data held with the answer
	logic [31:0] pat = 32'h0; // filler for a released bus
	// wire level: the unit wins while it drives; released lines never show stale data
	assign ad_i = ad_oe ? ad_o : (drv ? rdat : pat);
	// filler changes every clock, so a late sample cannot pass by luck
	always @(posedge hclk) begin
		pat <= ~pat;
	end
	// one answer per data phase, all timed on the bus clock
	initial begin
		ack_n = 1'h1;
		retry_n = 1'h1;
		bus_fault_n = 1'h1;
		forever begin
			@(posedge hclk);
			if (hresetn && !data_phase_n) begin
				repeat (slow) @(posedge hclk);
				seq[nb[2:0]] = word_index;
				// write data is taken when the acknowledge goes out
				if (!write_n) begin
					mem[word_index] = ad_o;
				end
				rdat <= mem[word_index];
				drv <= write_n;
				ack_n <= !(answer == 2'h0 || answer == 2'h3);
				retry_n <= answer != 2'h1;
				bus_fault_n <= !answer[1];
				repeat (6) @(posedge hclk);
				ack_n <= 1'h1;
				retry_n <= 1'h1;
				bus_fault_n <= 1'h1;
				drv <= 1'h0;
				nb++;
				repeat (2) @(posedge hclk);
			end
		end
	end
endmodule : msb_far_side

// ===== dv/muxed_system_bus_interface_bench.sv
/*
 * self-checking bench of the muxed bus unit: ahb-lite register tasks drive
 * transfers, the far-side model answers them, snapshots of the address cycle
 * are compared with values worked out from the size and width codes.
 * assumes zero-wait register slave and answers held past the synchroniser.
 */
module muxed_system_bus_interface_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ad_oe, ale, address_strobe_n;
	logic cycle_active_n, instr_data, read_n, write_n, data_phase_n, data_direction;
	logic ack_n, last_n, bus_fault_n, retry_n, bus_fault_event, dma_request_n;
	logic dma_grant_o, dma_grant_oe, power_on_reset_n, mode_gnt, gnt_pin;
	logic [31:0] haddr, hwdata, hrdata, ad_i, ad_o, st, d;
	logic [1:0] htrans, word_index, port_width, answer;
	logic [2:0] hsize;
	logic [3:0] lane_enable_n, irq_n, slow, lsnap; // lsnap: lanes of the first beat
	logic [4:0] trace_status;
	logic [9:0] boot_config_bits;
	logic [37:0] snap; // address cycle: ad, width, dir, read, write, instr
	int bad_count = 0;
	int n_compared = 0;
	int n_fault = 0;
	int nb0, f0;
	int n_be2 = 0; // data-phase clocks that used lane 2 on a 16-bit port
	// grant pin is an input while cold, then the unit drives it
	assign gnt_pin = dma_grant_oe ? dma_grant_o : mode_gnt;
	msb_biu dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .ad_i, .ad_o, .ad_oe, .word_index,
		.ale, .address_strobe_n, .port_width, .lane_enable_n, .cycle_active_n, .instr_data,
		.read_n, .write_n, .data_phase_n, .data_direction, .ack_n, .last_n, .bus_fault_n,
		.retry_n, .bus_fault_event, .dma_request_n, .dma_grant_i(gnt_pin), .dma_grant_o,
		.dma_grant_oe, .irq_n, .trace_status, .power_on_reset_n, .boot_config_bits);
	msb_far_side mem_u (.hclk, .hresetn, .ad_o, .ad_oe, .word_index, .data_phase_n,
		.write_n, .answer, .slow, .ad_i, .ack_n, .retry_n, .bus_fault_n);
	// bus clock, 25 ns
	initial begin
		hclk = 1'h0;
		forever #12.5 hclk = ~hclk;
	end
	// snapshot of each address cycle, unused lane on 16-bit ports, fault pulses
	always @(posedge hclk) begin
		if (!address_strobe_n) begin
			snap <= {ad_o, port_width, data_direction, read_n, write_n, instr_data};
			lsnap <= lane_enable_n;
		end
		if (port_width == msb_pkg::PW_16 && !data_phase_n && !lane_enable_n[2]) begin
			n_be2 <= n_be2 + 1;
		end
		if (bus_fault_event) begin
			n_fault <= n_fault + 1;
		end
	end
	task check(input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one single word transfer; address held until hready, then data phase
	task ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {24'h0, off};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask : ahb
	task wr(input logic [7:0] off, input logic [31:0] v);
		logic [31:0] x;
		ahb(1'h1, off, v, x);
	endtask : wr
	function automatic logic [31:0] cw(input logic i, input logic w, input logic [1:0] pw, input logic [3:0] sz);
		msb_pkg::msb_ctrl_t c;
		c = '{instr: i, write: w, width: pw, size: sz};
		return {24'h0, c};
	endfunction : cw
	// clear sticky flags, start a transfer, poll until not busy (bounded)
	task run(input logic [31:0] a, input logic [31:0] c);
		int k;
		wr(msb_pkg::OFF_STAT, 32'h0000_000E);
		wr(msb_pkg::OFF_ADDR, a);
		wr(msb_pkg::OFF_CTRL, c | (32'h1 << msb_pkg::CTRL_GO_BIT));
		st = 32'h1;
		k = 0;
		while (st[0] === 1'h1 && k < 500) begin
			ahb(1'h0, msb_pkg::OFF_STAT, 32'h0, st);
			k++;
		end
	endtask : run
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	// watchdog well beyond the few hundred clocks the sequence needs
	initial begin
		repeat (60000) @(posedge hclk);
		bad_count++;
		final_report();
	end
	initial begin
		hresetn = 1'h0;
		power_on_reset_n = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		irq_n = 4'hA;
		trace_status = 5'h15;
		mode_gnt = 1'h1;
		dma_request_n = 1'h1;
		answer = 2'h0;
		slow = 4'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		repeat (4) @(posedge hclk);
		power_on_reset_n <= 1'h1;
		repeat (8) @(posedge hclk);
		// pins change after cold reset; mode bits must not follow
		irq_n <= 4'h5;
		trace_status <= 5'h0A;
		repeat (4) @(posedge hclk);
		check(boot_config_bits, {4'hA, 1'h1, 5'h15});
		ahb(1'h0, msb_pkg::OFF_MODE, 32'h0, d);
		check(d, {22'h0, 4'hA, 1'h1, 5'h15});
		ahb(1'h0, msb_pkg::OFF_CTRL, 32'h0, d);
		check(d, {24'h0, msb_pkg::CTRL_RST});
		ahb(1'h0, 8'h40, 32'h0, d);
		check(d, 32'h0);
		check(hresp, 1'h0);
		// single word write on a 32-bit port
		wr(msb_pkg::OFF_DATA, 32'hA5C3_0F96);
		run(32'h0000_0100, cw(1'h0, 1'h1, msb_pkg::PW_32, msb_pkg::SZ_WORD));
		check(st[4:0], 5'h02);
		check(snap, {32'h0000_0104, msb_pkg::PW_32, 4'b1100});
		check(mem_u.mem[0], 32'hA5C3_0F96);
		// instruction fetch read of word 1
		mem_u.mem[1] = 32'h3C5A_9617;
		run(32'h0000_0204, cw(1'h1, 1'h0, msb_pkg::PW_32, msb_pkg::SZ_WORD));
		check(snap, {32'h0000_0204, msb_pkg::PW_32, 4'b0011});
		ahb(1'h0, msb_pkg::OFF_DATA, 32'h0, d);
		check(d, 32'h3C5A_9617);
		// every size code from 1 to 4 reaches the low lines
		for (int s = 1; s < 5; s++) begin
			run(32'h0000_0010, cw(1'h0, 1'h0, msb_pkg::PW_32, s[3:0]));
			check(snap[9:6], s[3:0]);
			check(lsnap, 4'(4'hF << s));
		end
		// block read from word 2 with a slow target: sub-block order
		mem_u.mem[2] = 32'h6E2B_D049;
		mem_u.mem[3] = 32'h91D4_2FB6;
		slow = 4'h5;
		nb0 = mem_u.nb;
		run(32'h0000_0308, cw(1'h0, 1'h0, msb_pkg::PW_32, msb_pkg::SZ_BLOCK));
		check(mem_u.nb - nb0, 4);
		check(snap[9:6], msb_pkg::SZ_BLOCK);
		for (int i = 0; i < 4; i++) begin
			check(mem_u.seq[(nb0 + i) & 7], 2'h2 ^ i[1:0]);
			ahb(1'h0, msb_pkg::OFF_DATA + 8'(4 * i), 32'h0, d);
			check(d, mem_u.mem[i]);
		end
		// block write back always starts at word 0
		slow = 4'h0;
		for (int i = 0; i < 4; i++) begin
			wr(msb_pkg::OFF_DATA + 8'(4 * i), 32'h1357_9BDF + 32'(i));
		end
		nb0 = mem_u.nb;
		run(32'h0000_040C, cw(1'h0, 1'h1, msb_pkg::PW_32, msb_pkg::SZ_BLOCK));
		for (int i = 0; i < 4; i++) begin
			check(mem_u.seq[(nb0 + i) & 7], i[1:0]);
			check(mem_u.mem[i], 32'h1357_9BDF + 32'(i));
		end
		// word read split over narrow ports
		for (int j = 0; j < 2; j++) begin
			f0 = n_be2;
			nb0 = mem_u.nb;
			run(32'h0000_0500, cw(1'h0, 1'h0, j ? msb_pkg::PW_8 : msb_pkg::PW_16, msb_pkg::SZ_WORD));
			check(mem_u.nb - nb0, j ? 4 : 2);
			check(snap[5:4], j ? msb_pkg::PW_8 : msb_pkg::PW_16);
			check(n_be2 - f0, 0);
			check(lsnap, j ? 4'hC : 4'h4);
		end
		// retry, fault, and fault together with acknowledge in the first phase
		for (int a = 1; a < 4; a++) begin
			wr(msb_pkg::OFF_DATA, 32'h0BAD_CAFE);
			answer = a[1:0];
			f0 = n_fault;
			run(32'h0000_0600, cw(1'h0, 1'h0, msb_pkg::PW_32, msb_pkg::SZ_WORD));
			answer = 2'h0;
			check(st[4:0], (a == 1) ? 5'h04 : 5'h08);
			check(n_fault - f0, (a == 1) ? 0 : 1);
			ahb(1'h0, msb_pkg::OFF_DATA, 32'h0, d);
			check(d, 32'h0BAD_CAFE);
		end
		// external master takes the bus and hands it back
		dma_request_n <= 1'h0;
		repeat (12) @(posedge hclk);
		check(dma_grant_o, 1'h0);
		ahb(1'h0, msb_pkg::OFF_STAT, 32'h0, d);
		check(d[4], 1'h1);
		dma_request_n <= 1'h1;
		repeat (12) @(posedge hclk);
		check(dma_grant_o, 1'h1);
		final_report();
	end
endmodule : muxed_system_bus_interface_bench

// ===== rtl/msb_biu.sv
/*
 * muxed address/data bus interface unit: ahb-lite register slave, transfer
 * engine for single, narrow-port and block transfers, dma grant exchange and
 * cold-reset configuration capture.
 * assumes bus pins arrive asynchronously and are held at least two clocks.
 */
module msb_biu (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [31:0] ad_i,
	output logic [31:0] ad_o,
	output logic ad_oe,
	output logic [1:0] word_index,
	output logic ale,
	output logic address_strobe_n,
	output logic [1:0] port_width,
	output logic [3:0] lane_enable_n,
	output logic cycle_active_n,
	output logic instr_data,
	output logic read_n,
	output logic write_n,
	output logic data_phase_n,
	output logic data_direction,
	input wire logic ack_n,
	output logic last_n,
	input wire logic bus_fault_n,
	input wire logic retry_n,
	output logic bus_fault_event,
	input wire logic dma_request_n,
	input wire logic dma_grant_i,
	output logic dma_grant_o,
	output logic dma_grant_oe,
	input wire logic [3:0] irq_n,
	input wire logic [4:0] trace_status,
	input wire logic power_on_reset_n,
	output logic [9:0] boot_config_bits
);
	// bytes carried by the beat starting at byte pointer bp
	function automatic logic [4:0] take_f(logic [3:0] bp, logic [4:0] rem, logic [1:0] pw);
		logic [4:0] room;
		room = 5'h1;
		if (pw == msb_pkg::PW_16) begin
			room = bp[0] ? 5'h1 : 5'h2;
		end else if (pw == msb_pkg::PW_32) begin
			room = 5'h4 - {3'h0, bp[1:0]};
		end
		return (rem < room) ? rem : room;
	endfunction : take_f

	// active-low lane enables for one beat
	function automatic logic [3:0] lanes_f(logic [3:0] bp, logic [4:0] tk, logic [1:0] pw);
		logic [4:0] m;
		m = 5'((5'h1 << tk) - 5'h1);
		if (pw == msb_pkg::PW_32) begin
			return ~(4'(m[3:0] << bp[1:0]));
		end else if (pw == msb_pkg::PW_16) begin
			return {~(bp[0] | (tk == 5'h2)), 1'b1, bp[1], bp[0]};
		end
		return {2'h3, bp[1], bp[0]};
	endfunction : lanes_f

	// beat data on the low lines, same lines whatever the byte order
	function automatic logic [31:0] beat_f(logic [31:0] w, logic [3:0] bp, logic [1:0] pw);
		if (pw == msb_pkg::PW_32) begin
			return w;
		end else if (pw == msb_pkg::PW_16) begin
			return {16'h0000, bp[1] ? w[31:16] : w[15:0]};
		end
		return {24'h00_0000, w[{bp[1:0], 3'h0} +: 8]};
	endfunction : beat_f

	// merge one returned beat into a buffered word
	function automatic logic [31:0] merge_f(logic [31:0] w, logic [31:0] d, logic [3:0] bp, logic [1:0] pw);
		logic [31:0] r;
		r = w;
		if (pw == msb_pkg::PW_32) begin
			r = d;
		end else if (pw == msb_pkg::PW_16) begin
			r[{bp[1], 4'h0} +: 16] = d[15:0];
		end else begin
			r[{bp[1:0], 3'h0} +: 8] = d[7:0];
		end
		return r;
	endfunction : merge_f

	// three-flop pin synchroniser, a change counts once stages 2 and 3 agree
	msb_pkg::msb_pins_t s1_q, s2_q, s3_q, pin_q, pin_prev_q;
	msb_pkg::msb_pins_t pin_raw;
	assign pin_raw = {power_on_reset_n, ack_n, retry_n, bus_fault_n, dma_request_n,
		dma_grant_i, irq_n, trace_status, ad_i};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= msb_pkg::SYNC_RST;
			s2_q <= msb_pkg::SYNC_RST;
			s3_q <= msb_pkg::SYNC_RST;
			pin_q <= msb_pkg::SYNC_RST;
			pin_prev_q <= msb_pkg::SYNC_RST;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q)); // keep old bit on disagreement
			pin_prev_q <= pin_q;
		end
	end

	// falling edges of the filtered handshake inputs
	logic ack_ev, retry_ev_raw, fault_ev_raw, cold;
	assign ack_ev = pin_prev_q.ack_n & ~pin_q.ack_n;
	assign retry_ev_raw = pin_prev_q.retry_n & ~pin_q.retry_n;
	assign fault_ev_raw = pin_prev_q.fault_n & ~pin_q.fault_n;
	assign cold = ~pin_q.por_n; // cold reset still active

	// configuration bits follow the pins during cold reset, frozen at release
	logic [9:0] mode_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= msb_pkg::MODE_RST;
		end else if (cold) begin
			mode_q <= {pin_q.irq_n, pin_q.gnt, pin_q.trace};
		end
	end
	assign boot_config_bits = mode_q;

	// ahb-lite slave: always ready, always okay, one-cycle read data
	logic dph_wr_q;
	logic [7:0] dph_off_q;
	logic [31:0] rdata_q;
	logic [31:0] addr_q;
	msb_pkg::msb_ctrl_t ctrl_q;
	logic aph, go_wr, stat_wr;
	assign aph = hsel & hready & htrans[1];
	assign go_wr = dph_wr_q & (dph_off_q == msb_pkg::OFF_CTRL) & hwdata[msb_pkg::CTRL_GO_BIT];
	assign stat_wr = dph_wr_q & (dph_off_q == msb_pkg::OFF_STAT);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	msb_pkg::msb_state_t st_q;
	msb_pkg::msb_stat_t stat;
	logic [31:0] buf_q [4];
	logic go_q, done_q, retried_q, fault_q;
	assign stat = '{granted: (st_q == msb_pkg::ST_GRANT), fault: fault_q, retried: retried_q,
		done: done_q, busy: go_q | (st_q != msb_pkg::ST_IDLE)};

	// address phase capture and registered read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_q <= 1'b0;
			dph_off_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end else begin
			dph_wr_q <= aph & hwrite;
			dph_off_q <= haddr[7:0];
			if (aph & ~hwrite) begin
				unique case (haddr[7:0])
					msb_pkg::OFF_ADDR: rdata_q <= addr_q;
					msb_pkg::OFF_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
					msb_pkg::OFF_STAT: rdata_q <= {27'h000_0000, stat};
					msb_pkg::OFF_MODE: rdata_q <= {22'h00_0000, mode_q};
					8'h10, 8'h14, 8'h18, 8'h1C: rdata_q <= buf_q[haddr[3:2]];
					default: rdata_q <= 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end

	// address and ctrl registers, frozen while a transfer runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= msb_pkg::ADDR_RST;
			ctrl_q <= msb_pkg::CTRL_RST;
		end else if (dph_wr_q && !stat.busy) begin
			if (dph_off_q == msb_pkg::OFF_ADDR) begin
				addr_q <= hwdata;
			end
			if (dph_off_q == msb_pkg::OFF_CTRL) begin
				ctrl_q.instr <= hwdata[7];
				ctrl_q.write <= hwdata[6];
				// reserved width code folds to 32-bit
				ctrl_q.width <= (hwdata[5:4] == 2'h3) ? msb_pkg::PW_32 : hwdata[5:4];
				// unsupported size codes fold to one word
				ctrl_q.size <= (hwdata[3:0] > msb_pkg::SZ_WORD) ? msb_pkg::SZ_WORD : hwdata[3:0];
			end
		end
	end

	// per-beat arithmetic for the engine
	logic [3:0] bp_q, bp_nx;
	logic [4:0] rem_q, rem_nx, tk, tk_nx;
	logic [1:0] start_w_q, wsel, wsel_nx;
	logic first_q, blk, fault_ev, retry_ev, accept;
	assign blk = (ctrl_q.size == msb_pkg::SZ_BLOCK);
	assign tk = take_f(bp_q, rem_q, ctrl_q.width);
	assign bp_nx = bp_q + tk[3:0];
	assign rem_nx = rem_q - tk;
	assign tk_nx = take_f(bp_nx, rem_nx, ctrl_q.width);
	// reads of a block walk sub-blocks from the critical word, writes from word 0
	assign wsel = bp_q[3:2] ^ start_w_q;
	assign wsel_nx = bp_nx[3:2] ^ start_w_q;
	// bus fault counts only before the first acknowledged data
	assign fault_ev = (st_q == msb_pkg::ST_DATA) & fault_ev_raw & first_q;
	// ack loses to a fault in the first phase
	assign accept = (st_q == msb_pkg::ST_DATA) & ack_ev & ~fault_ev;
	// retry without ack: reads before first data, writes in any phase
	assign retry_ev = (st_q == msb_pkg::ST_DATA) & retry_ev_raw & ~ack_ev & ~fault_ev
		& (ctrl_q.write | first_q);

	// transfer engine, buffer and status flags
	logic [31:0] ad_q;
	logic [3:0] lane_q;
	logic [1:0] gcnt_q;
	logic fault_pulse_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= msb_pkg::ST_IDLE;
			go_q <= 1'b0;
			bp_q <= 4'h0;
			rem_q <= 5'h00;
			start_w_q <= 2'h0;
			first_q <= 1'b0;
			ad_q <= 32'h0000_0000;
			lane_q <= 4'hF;
			gcnt_q <= 2'h0;
			done_q <= 1'b0;
			retried_q <= 1'b0;
			fault_q <= 1'b0;
			fault_pulse_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				buf_q[i] <= 32'h0000_0000;
			end
		end else begin
			fault_pulse_q <= 1'b0;
			// write-one-to-clear, an event in the same cycle wins
			if (stat_wr) begin
				done_q <= done_q & ~hwdata[1];
				retried_q <= retried_q & ~hwdata[2];
				fault_q <= fault_q & ~hwdata[3];
			end
			// software fills the buffer only while idle
			if (dph_wr_q && !stat.busy && dph_off_q[7:4] == msb_pkg::OFF_DATA[7:4]) begin
				buf_q[dph_off_q[3:2]] <= hwdata;
			end
			// start request is refused during cold reset and while busy
			if (go_wr && !stat.busy && !cold) begin
				go_q <= 1'b1;
			end
			unique case (st_q)
				msb_pkg::ST_IDLE: begin
					if (!pin_q.req_n && !cold) begin
						st_q <= msb_pkg::ST_GRANT;
						gcnt_q <= 2'h0;
					end else if (go_q) begin
						go_q <= 1'b0;
						st_q <= msb_pkg::ST_ADDR;
						first_q <= 1'b1;
						bp_q <= blk ? 4'h0 : {2'h0, addr_q[1:0]};
						rem_q <= blk ? msb_pkg::BLOCK_BYTES : {1'b0, ctrl_q.size};
						start_w_q <= (blk && !ctrl_q.write) ? addr_q[3:2] : 2'h0;
						ad_q <= {addr_q[31:4], ctrl_q.size};
						lane_q <= lanes_f(blk ? 4'h0 : {2'h0, addr_q[1:0]},
							take_f(blk ? 4'h0 : {2'h0, addr_q[1:0]},
							blk ? msb_pkg::BLOCK_BYTES : {1'b0, ctrl_q.size}, ctrl_q.width),
							ctrl_q.width);
					end
				end
				msb_pkg::ST_ADDR: begin
					// address cycle is one clock; first beat data follows
					st_q <= msb_pkg::ST_DATA;
					ad_q <= ctrl_q.write ? beat_f(buf_q[wsel], bp_q, ctrl_q.width) : 32'h0000_0000;
				end
				msb_pkg::ST_DATA: begin
					if (fault_ev) begin
						st_q <= msb_pkg::ST_IDLE;
						fault_q <= 1'b1;
						fault_pulse_q <= 1'b1;
					end else if (retry_ev) begin
						st_q <= msb_pkg::ST_IDLE;
						retried_q <= 1'b1;
					end else if (accept) begin
						first_q <= 1'b0;
						if (!ctrl_q.write) begin
							buf_q[wsel] <= merge_f(buf_q[wsel], pin_q.ad, bp_q, ctrl_q.width);
						end
						if (rem_nx == 5'h00) begin
							st_q <= msb_pkg::ST_IDLE;
							done_q <= 1'b1;
						end else begin
							bp_q <= bp_nx;
							rem_q <= rem_nx;
							lane_q <= lanes_f(bp_nx, tk_nx, ctrl_q.width);
							ad_q <= ctrl_q.write ? beat_f(buf_q[wsel_nx], bp_nx, ctrl_q.width) : 32'h0000_0000;
						end
					end
				end
				msb_pkg::ST_GRANT: begin
					if (gcnt_q != msb_pkg::GNT_MIN_CYC) begin
						gcnt_q <= gcnt_q + 2'h1;
					end else if (pin_q.req_n) begin
						st_q <= msb_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// bus outputs decoded from engine state; no parity lines exist at all
	logic act;
	assign act = (st_q == msb_pkg::ST_ADDR) | (st_q == msb_pkg::ST_DATA);
	assign address_strobe_n = ~(st_q == msb_pkg::ST_ADDR);
	assign ale = ~address_strobe_n;
	assign ad_o = ad_q;
	assign ad_oe = (st_q == msb_pkg::ST_ADDR) | ((st_q == msb_pkg::ST_DATA) & ctrl_q.write);
	assign port_width = act ? ctrl_q.width : msb_pkg::PW_32;
	assign lane_enable_n = act ? lane_q : 4'hF;
	assign word_index = (st_q == msb_pkg::ST_DATA && blk) ? wsel : addr_q[3:2]; // singles stay on their own word
	assign cycle_active_n = ~act;
	assign instr_data = act & ctrl_q.instr;
	assign read_n = ~(act & ~ctrl_q.write);
	assign write_n = ~(act & ctrl_q.write);
	assign data_phase_n = ~(st_q == msb_pkg::ST_DATA);
	assign data_direction = act & ctrl_q.write;
	assign last_n = ~((st_q == msb_pkg::ST_DATA) & (tk == rem_q));
	assign bus_fault_event = fault_pulse_q;
	// grant pin is an input while cold reset lasts
	assign dma_grant_oe = ~cold;
	// grant rises early once the minimum passed and the core wants the bus
	assign dma_grant_o = ~((st_q == msb_pkg::ST_GRANT)
		& ~((gcnt_q == msb_pkg::GNT_MIN_CYC) & go_q));

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_strobe_inverse:
	assert property (ale == !address_strobe_n and ($fell(address_strobe_n) |=> address_strobe_n))
		else $error("address strobe not a one-cycle inverse of latch");
	a_width_legal:
	assert property (port_width != 2'h3)
		else $error("reserved port width driven");
	a_size_code:
	assert property (!address_strobe_n |-> ad_oe && ad_o[3:0] == ctrl_q.size && ad_o[31:4] == addr_q[31:4])
		else $error("address phase lines wrong");
	a_strobe_excl:
	assert property (!(!read_n && !write_n) and (!write_n |-> data_direction) and (!read_n |-> !data_direction))
		else $error("read/write strobes or direction wrong");
	a_addr_to_data:
	assert property (!address_strobe_n |=> !data_phase_n && address_strobe_n && !cycle_active_n)
		else $error("data phase did not follow address cycle");
	a_cycle_until_ack:
	assert property ((!data_phase_n && !last_n && accept) |=> cycle_active_n && data_phase_n)
		else $error("cycle not closed after last acknowledge");
	a_grant_min:
	assert property ($fell(dma_grant_o) |=> !dma_grant_o)
		else $error("grant low for under two clocks");
	a_fault_wins:
	assert property ((st_q == msb_pkg::ST_DATA && first_q && fault_ev_raw && ack_ev) |=> fault_q && bus_fault_event
		&& cycle_active_n)
		else $error("fault did not beat acknowledge");
	a_read_retry:
	assert property ((st_q == msb_pkg::ST_DATA && !first_q && !ctrl_q.write && retry_ev_raw && !ack_ev)
		|=> st_q == msb_pkg::ST_DATA && !$rose(retried_q))
		else $error("retry honoured after first read data");
endmodule : msb_biu

// ===== rtl/msb_pkg.sv
/*
 * constants, state codes and carrier types of the muxed system bus unit.
 * assumes one bus clock and software access over an ahb-lite register slave.
 */
package msb_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_ADDR = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0C;
	localparam logic [7:0] OFF_DATA = 8'h10; // four words, 0x10..0x1C
	localparam int CTRL_GO_BIT = 8; // write-only start bit of ctrl
	// size codes on the low address lines
	localparam logic [3:0] SZ_BLOCK = 4'h0;
	localparam logic [3:0] SZ_WORD = 4'h4;
	localparam logic [4:0] BLOCK_BYTES = 5'h10;
	// port width codes, 2'h3 is reserved
	localparam logic [1:0] PW_8 = 2'h0;
	localparam logic [1:0] PW_16 = 2'h1;
	localparam logic [1:0] PW_32 = 2'h2;
	// grant held low at least this many bus clocks
	localparam logic [1:0] GNT_MIN_CYC = 2'h2;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h24;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [9:0] MODE_RST = 10'h000;
	localparam logic [46:0] SYNC_RST = 47'h3FFF_FFFF_FFFF;
	// engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_DATA = 4'b0100,
		ST_GRANT = 4'b1000
	} msb_state_t;
	// transfer request fields of ctrl
	typedef struct packed {
		logic instr;
		logic write;
		logic [1:0] width;
		logic [3:0] size;
	} msb_ctrl_t;
	// status register fields
	typedef struct packed {
		logic granted;
		logic fault;
		logic retried;
		logic done;
		logic busy;
	} msb_stat_t;
	// pin inputs that pass the synchroniser together
	typedef struct packed {
		logic por_n;
		logic ack_n;
		logic retry_n;
		logic fault_n;
		logic req_n;
		logic gnt;
		logic [3:0] irq_n;
		logic [4:0] trace;
		logic [31:0] ad;
	} msb_pins_t;
endpackage : msb_pkg
